// ==== hw/adc_flow_error_flags.sv ====
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps

// Function
// - Trigger error flag halts converter while set
// - Restart before list end sets restart error
// - No restart error on restart overrun
// - Restart mode: restart without load-ok flags error
// - No load-ok error during or with abort
// - Suppress load-ok error first restart, single buffer
// - Load-ok error lets conversion keep running
// - Illegal fetch address sets severe read error
module adc_flow_error_flags (
  // Clock and reset.
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Register bus.
  input  wire flow_err_pkg::axil_req_t    bus_req,
  output flow_err_pkg::axil_rsp_t         bus_rsp,
  // Sequencer events and indications.
  input  wire flow_err_pkg::conv_events_t ev,
  input  wire logic                      load_ok_indication,
  // Command fetch address.
  input  wire logic                      fetch_valid,
  input  wire logic [31:0]               fetch_addr,
  // Converter state and interrupt.
  output logic                           converter_run,
  output logic                           converter_halted,
  output logic                           sequence_abort_active,
  output logic                           irq
);

  // Bus side decode signals.
  logic        wr_req;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_lane0;

  // Software registers.
  logic [7:0] mask_q, mask_d;
  logic [3:0] control_q, control_d;
  logic       enable, restart_mode, single_buffer, store_on_abort;

  // Sequence tracking state.
  logic seq_open_q, seq_open_d;
  logic restart_pend_q, restart_pend_d;
  logic abort_act_q, abort_act_d;
  logic first_restart_q, first_restart_d;
  logic enable_last_q, enable_last_d;

  // Number of flag cells; the upper register bits are not built here.
  localparam int unsigned NUM_FLAGS_W = flow_err_pkg::NUM_FLAGS;

  // Flag bits.
  logic [NUM_FLAGS_W-1:0] flag_set;
  logic [NUM_FLAGS_W-1:0] flag_clr;
  logic [NUM_FLAGS_W-1:0] flag_q;
  logic [7:0]             converter_error_flags;
  logic                   severe;
  logic                   list_end_reached;
  logic                   fetch_legal;

  // Bus front end: it owns the handshakes, this module owns the decode.
  // A write reaches the registers one cycle after both channels are held,
  // and read data are taken from the decode below at the address edge.
  axil_port u_port (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus_req (bus_req),
    .bus_rsp (bus_rsp),
    .wr_req  (wr_req),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // Control fields. Clearing enable also clears the sequence tracking,
  // so a converter that is switched off forgets any open list, pending
  // restart or running abort.
  assign enable         = control_q[flow_err_pkg::CTL_ENABLE_BIT];
  assign restart_mode   = control_q[flow_err_pkg::CTL_RESTART_BIT];
  assign single_buffer  = control_q[flow_err_pkg::CTL_SINGLE_BIT];
  assign store_on_abort = control_q[flow_err_pkg::CTL_STORE_AB_BIT];

  // Registers hold up to eight bits in byte lane 0.
  // A write with lane 0 off is answered but changes nothing.
  assign wr_lane0 = wr_req && wr_strb[0];

  // Write decode; unmapped addresses answer with an error.
  // The status register is read-only; a write to it is accepted and lost.
  always_comb begin
    wr_ok = 1'b1;
    case (wr_addr)
      flow_err_pkg::ERR_FLAGS_OFS: wr_ok = 1'b1;
      flow_err_pkg::IRQ_MASK_OFS:  wr_ok = 1'b1;
      flow_err_pkg::CONTROL_OFS:   wr_ok = 1'b1;
      flow_err_pkg::STATUS_OFS:    wr_ok = 1'b1;
      default:                     wr_ok = 1'b0;
    endcase
  end

  // Mask and control registers.
  // Mask bits above the built flags stay zero, so that they can never
  // raise the interrupt.
  always_comb begin
    mask_d    = mask_q;
    control_d = control_q;
    if (wr_lane0 && wr_addr == flow_err_pkg::IRQ_MASK_OFS) begin
      mask_d = wr_data[7:0] & flow_err_pkg::FLAG_IMPL_MASK;
    end
    if (wr_lane0 && wr_addr == flow_err_pkg::CONTROL_OFS) begin
      control_d = wr_data[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q    <= flow_err_pkg::MASK_RESET;
      control_q <= flow_err_pkg::CONTROL_RESET;
    end else begin
      mask_q    <= mask_d;
      control_q <= control_d;
    end
  end

  // The list counts as finished once end-of-list ran or, with
  // store-on-abort set, is about to run, or once an abort hits it.
  // The abort counts from its request, so a restart that coincides
  // with the abort request is no order error either.
  assign list_end_reached = ev.eol_executed
                         || (store_on_abort && ev.eol_about)
                         || ev.abort_request
                         || abort_act_q;

  // Sequence, restart, abort and first-restart tracking.
  always_comb begin
    seq_open_d      = seq_open_q;
    restart_pend_d  = restart_pend_q;
    abort_act_d     = abort_act_q;
    first_restart_d = first_restart_q;
    enable_last_d   = enable;
    if (ev.trigger_event) begin
      seq_open_d = 1'b1;
    end
    if (ev.eol_executed || ev.abort_done) begin
      seq_open_d = 1'b0;
    end
    if (store_on_abort && ev.eol_about) begin
      seq_open_d = 1'b0;
    end
    // A restart stays pending until the sequencer reports it done; a
    // second request inside that window is an overrun.
    if (ev.restart_done) begin
      restart_pend_d = 1'b0;
    end
    if (ev.restart_request) begin
      restart_pend_d  = 1'b1;
      first_restart_d = 1'b0;
    end
    // A new abort request wins over one that ends in the same cycle.
    if (ev.abort_done) begin
      abort_act_d = 1'b0;
    end
    if (ev.abort_request) begin
      abort_act_d = 1'b1;
    end
    if ((enable && !enable_last_q) || ev.stop_mode_exit) begin
      first_restart_d = 1'b1;
    end
    // Switching off drops the open list, pending restart and running abort.
    if (!enable) begin
      seq_open_d     = 1'b0;
      restart_pend_d = 1'b0;
      abort_act_d    = 1'b0;
    end
  end

  // Tracking registers; enable_last_q resets to the reset enable, so
  // no false enable edge follows reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_open_q      <= 1'b0;
      restart_pend_q  <= 1'b0;
      abort_act_q     <= 1'b0;
      first_restart_q <= 1'b0;
      enable_last_q   <= 1'b0;
    end else begin
      seq_open_q      <= seq_open_d;
      restart_pend_q  <= restart_pend_d;
      abort_act_q     <= abort_act_d;
      first_restart_q <= first_restart_d;
      enable_last_q   <= enable_last_d;
    end
  end

  // A fetch is legal only inside system RAM or the NVM area.
  // Both areas include their end addresses; one byte past either end
  // is already illegal.
  assign fetch_legal =
      (fetch_addr >= flow_err_pkg::RAM_BASE
       && fetch_addr <= flow_err_pkg::RAM_LAST)
   || (fetch_addr >= flow_err_pkg::NVM_BASE
       && fetch_addr <= flow_err_pkg::NVM_LAST);

  // Set conditions of each flag, gated by the enable.
  // Every set needs the enable, so a disabled converter raises no flag
  // even when the sequencer keeps pulsing events.
  always_comb begin
    flag_set = '0;
    flag_set[flow_err_pkg::TRIG_ERR_BIT] = enable && ev.trigger_error_event;
    // An order error needs an open list, no list end and no pending
    // restart; a pending restart is the overrun that stays silent.
    // restart order error.
    flag_set[flow_err_pkg::RESTART_ERR_BIT] = enable && ev.restart_request
                                           && seq_open_q
                                           && !list_end_reached
                                           && !restart_pend_q;
    // The first restart after enable or stop exit, and any restart with
    // single buffering, needs no load-ok and is no error.
    // load-ok error.
    flag_set[flow_err_pkg::LOAD_OK_ERR_BIT] = enable && restart_mode
                                           && ev.restart_request
                                           && !load_ok_indication
                                           && !abort_act_q
                                           && !ev.abort_request
                                           && !first_restart_q
                                           && !single_buffer;
    // A bad fetch is caught only in the cycle its valid is high.
    // illegal fetch address.
    flag_set[flow_err_pkg::READ_ERR_BIT] = enable && fetch_valid
                                        && !fetch_legal;
  end

  // Software clears a flag by writing one to it.
  // Data bits above the built flags are ignored.
  assign flag_clr = (wr_lane0 && wr_addr == flow_err_pkg::ERR_FLAGS_OFS)
                  ? wr_data[NUM_FLAGS_W-1:0] : '0;

  // One sticky cell per flag.
  // Set wins over a same-cycle clear, so an event that lands together
  // with the software clear is never lost.
  for (genvar i = 0; i < NUM_FLAGS_W; i++) begin : g_flag
    sticky_flag u_flag (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set     (flag_set[i]),
      .clr     (flag_clr[i]),
      .q       (flag_q[i])
    );
  end

  // Reserved and out-of-scope bits read as zero.
  assign converter_error_flags = {4'h0, flag_q};

  // Only the trigger and read errors are severe; the restart order and
  // load-ok errors are reported while the converter carries on.
  // trigger error halts.
  assign severe = flag_q[flow_err_pkg::TRIG_ERR_BIT]
               || flag_q[flow_err_pkg::READ_ERR_BIT];

  // Converter state outputs.
  // Both are low while disabled, so halted shows only for an enabled
  // converter that a severe flag has stopped.
  assign converter_run         = enable && !severe;
  assign converter_halted      = enable && severe;
  assign sequence_abort_active = abort_act_q;

  // One level interrupt for all unmasked flags.
  // Masked flags still read back; only the interrupt ignores them.
  assign irq = |(converter_error_flags & mask_q);

  // Read decode; unmapped addresses answer with an error.
  // Read data are sampled at the address edge, so a flag set in that
  // very cycle shows up on the next read.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (rd_addr)
      flow_err_pkg::ERR_FLAGS_OFS: rd_data[7:0] = converter_error_flags;
      flow_err_pkg::IRQ_MASK_OFS:  rd_data[7:0] = mask_q;
      flow_err_pkg::CONTROL_OFS:   rd_data[3:0] = control_q;
      flow_err_pkg::STATUS_OFS:    rd_data[3:0] = {seq_open_q, abort_act_q,
                                                   converter_halted,
                                                   converter_run};
      default:                     rd_ok = 1'b0;
    endcase
  end

endmodule : adc_flow_error_flags

// ==== hw/flow_err_pkg.sv ====
package flow_err_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [11:0] ERR_FLAGS_OFS = 12'h0_000;
  localparam logic [11:0] IRQ_MASK_OFS  = 12'h0_004;
  localparam logic [11:0] CONTROL_OFS   = 12'h0_008;
  localparam logic [11:0] STATUS_OFS    = 12'h0_00C;

  // Bit positions inside the error flag register.
  localparam int unsigned TRIG_ERR_BIT    = 3;
  localparam int unsigned RESTART_ERR_BIT = 2;
  localparam int unsigned LOAD_OK_ERR_BIT = 1;
  localparam int unsigned READ_ERR_BIT    = 0;
  localparam int unsigned NUM_FLAGS       = 4;

  // Bits that software may clear or mask.
  localparam logic [7:0] FLAG_IMPL_MASK = 8'h0_F;

  // Bit positions inside the control register.
  localparam int unsigned CTL_ENABLE_BIT   = 0;
  localparam int unsigned CTL_RESTART_BIT  = 1;
  localparam int unsigned CTL_SINGLE_BIT   = 2;
  localparam int unsigned CTL_STORE_AB_BIT = 3;

  // Values after reset.
  localparam logic [7:0] FLAGS_RESET   = 8'h0_0;
  localparam logic [7:0] MASK_RESET    = 8'h0_0;
  localparam logic [3:0] CONTROL_RESET = 4'h0;

  // Address areas from which command fetches are legal.
  localparam logic [31:0] RAM_BASE = 32'h2000_0000;
  localparam logic [31:0] RAM_LAST = 32'h2000_0FFF;
  localparam logic [31:0] NVM_BASE = 32'h0000_0000;
  localparam logic [31:0] NVM_LAST = 32'h0000_FFFF;

  // AXI4-Lite response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Master to slave signals of the register bus.
  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;

  // Slave to master signals of the register bus.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;

  // One-cycle event pulses from the sequencer around this block.
  typedef struct packed {
    logic trigger_event;
    logic trigger_error_event;
    logic restart_request;
    logic restart_done;
    logic abort_request;
    logic abort_done;
    logic eol_executed;
    logic eol_about;
    logic stop_mode_exit;
  } conv_events_t;

endpackage : flow_err_pkg

// ==== hw/sticky_flag.sv ====
`timescale 1ns/10ps

// One sticky flag bit; a set in the same cycle as a clear wins.
module sticky_flag (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Set and clear strobes.
  input  wire logic set,
  input  wire logic clr,
  // Flag state.
  output logic      q
);

  logic q_d;
  logic q_q;

  // Next value: set has priority over clear.
  always_comb begin
    q_d = q_q;
    if (clr) begin
      q_d = 1'b0;
    end
    if (set) begin
      q_d = 1'b1;
    end
  end

  // Flag register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_q <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule : sticky_flag

// ==== hw/axil_port.sv ====
`timescale 1ns/10ps

// AXI4-Lite slave front end; the register decode lives in the parent.
module axil_port (
  // Clock and reset.
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Bus.
  input  wire flow_err_pkg::axil_req_t bus_req,
  output flow_err_pkg::axil_rsp_t      bus_rsp,
  // Register write strobe and decode answer.
  output logic                        wr_req,
  output logic [11:0]                 wr_addr,
  output logic [31:0]                 wr_data,
  output logic [3:0]                  wr_strb,
  input  wire logic                   wr_ok,
  // Register read address and decode answer.
  output logic [11:0]                 rd_addr,
  input  wire logic [31:0]            rd_data,
  input  wire logic                   rd_ok
);

  logic        aw_full_q, aw_full_d;
  logic        w_full_q, w_full_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        aw_take, w_take, ar_take;

  // Address and data are taken in either order, one write at a time.
  assign aw_take = bus_req.awvalid && !aw_full_q;
  assign w_take  = bus_req.wvalid && !w_full_q;
  assign ar_take = bus_req.arvalid && !rvalid_q;
  assign wr_req  = aw_full_q && w_full_q && !bvalid_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_addr = bus_req.araddr;

  // Next state of both channels.
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (aw_take) begin
      aw_full_d = 1'b1;
      awaddr_d  = bus_req.awaddr;
    end
    if (w_take) begin
      w_full_d = 1'b1;
      wdata_d  = bus_req.wdata;
      wstrb_d  = bus_req.wstrb;
    end
    if (wr_req) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? flow_err_pkg::RESP_OKAY : flow_err_pkg::RESP_SLVERR;
    end else if (bvalid_q && bus_req.bready) begin
      bvalid_d = 1'b0;
    end
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_data;
      rresp_d  = rd_ok ? flow_err_pkg::RESP_OKAY : flow_err_pkg::RESP_SLVERR;
    end else if (rvalid_q && bus_req.rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 12'h0_00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Bus outputs.
  always_comb begin
    bus_rsp         = '0;
    bus_rsp.awready = !aw_full_q;
    bus_rsp.wready  = !w_full_q;
    bus_rsp.bvalid  = bvalid_q;
    bus_rsp.bresp   = bresp_q;
    bus_rsp.arready = !rvalid_q;
    bus_rsp.rvalid  = rvalid_q;
    bus_rsp.rresp   = rresp_q;
    bus_rsp.rdata   = rdata_q;
  end

endmodule : axil_port

// ==== sim/flow_checker.sv ====
`timescale 1ns/10ps

// Watches the error flag block from its ports only.
module flow_checker (
  // Clock and reset.
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Register bus.
  input wire flow_err_pkg::axil_req_t    bus_req,
  input wire flow_err_pkg::axil_rsp_t    bus_rsp,
  // Sequencer side.
  input wire flow_err_pkg::conv_events_t ev,
  input wire logic                       load_ok_indication,
  input wire logic                       fetch_valid,
  input wire logic [31:0]                fetch_addr,
  // Converter state.
  input wire logic                       converter_run,
  input wire logic                       converter_halted,
  input wire logic                       sequence_abort_active,
  input wire logic                       irq
);
  logic on_w;
  logic bad_w;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Enable shows as run or halted; fetches are legal in RAM and NVM only.
  assign on_w  = converter_run | converter_halted;
  assign bad_w = !((fetch_addr >= flow_err_pkg::RAM_BASE &&
                    fetch_addr <= flow_err_pkg::RAM_LAST) ||
                   fetch_addr <= flow_err_pkg::NVM_LAST);

  // Both write channels taken at one edge.
  sequence wr_taken;
    bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready;
  endsequence
  // A register write has just landed.
  sequence wr_landed;
    $rose(bus_rsp.bvalid);
  endsequence

  wr_resp_a: assert property (wr_taken |-> ##2 bus_rsp.bvalid)
    else $error("write response late");
  rd_resp_a: assert property (bus_req.arvalid && bus_rsp.arready
    |=> bus_rsp.rvalid && !bus_rsp.arready)
    else $error("read response late");
  trig_halt_a: assert property (
    on_w && ev.trigger_error_event
    |=> (converter_halted && !converter_run) or wr_landed)
    else $error("trigger error did not halt");
  read_halt_a: assert property (
    on_w && fetch_valid && bad_w |=> converter_halted or wr_landed)
    else $error("bad fetch did not halt");
  restart_runs_a: assert property (
    converter_run && ev.restart_request && !ev.trigger_error_event &&
    !(fetch_valid && bad_w) |=> converter_run or wr_landed)
    else $error("restart stopped the converter");
  halt_hold_a: assert property (
    $fell(converter_halted) |-> wr_landed)
    else $error("halt left without a write");
  irq_cause_a: assert property (
    $rose(irq) |-> wr_landed or ($past(ev.trigger_error_event) ||
    $past(ev.restart_request) || $past(fetch_valid)))
    else $error("interrupt without cause");
  irq_drop_a: assert property (
    $fell(irq) |-> wr_landed)
    else $error("interrupt dropped by itself");
  abort_set_a: assert property (
    on_w && ev.abort_request && !ev.abort_done |=> sequence_abort_active)
    else $error("abort not tracked");
  abort_clr_a: assert property (
    sequence_abort_active && ev.abort_done && !ev.abort_request
    |=> !sequence_abort_active)
    else $error("abort not finished");
endmodule : flow_checker

bind adc_flow_error_flags flow_checker u_flow_checker (
  .aclk(aclk), .aresetn(aresetn), .bus_req(bus_req), .bus_rsp(bus_rsp),
  .ev(ev), .load_ok_indication(load_ok_indication),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
  .converter_run(converter_run), .converter_halted(converter_halted),
  .sequence_abort_active(sequence_abort_active), .irq(irq));

// ==== sim/ev_source.sv ====
`timescale 1ns/10ps

// Event sources around the block: one-cycle pulses and the load-ok level.
module ev_source (
  // Clock.
  input wire logic                   aclk,
  // Toward the block.
  output flow_err_pkg::conv_events_t ev,
  output logic                       load_ok_indication
);
  // Lines idle at time zero.
  initial begin
    ev = '0;
    load_ok_indication = 1'h0;
  end

  // Pulse the chosen events for exactly one cycle.
  task fire(input logic [8:0] e);
    @(posedge aclk);
    ev <= flow_err_pkg::conv_events_t'(e);
    @(posedge aclk);
    ev <= '0;
  endtask : fire

  // Change the load-ok level just after an edge.
  task set_ok(input logic v);
    @(posedge aclk);
    load_ok_indication <= v;
  endtask : set_ok
endmodule : ev_source

// ==== sim/adc_flow_error_flags_tb.sv ====
`timescale 1ns/10ps

module adc_flow_error_flags_tb;
  localparam logic [8:0] TRG = 9'h100, TER = 9'h080, RST = 9'h040;
  localparam logic [8:0] RDN = 9'h020, ABR = 9'h010, ABD = 9'h008;
  localparam logic [8:0] EOL = 9'h004, EOA = 9'h002, STP = 9'h001;
  logic                       aclk;
  logic                       aresetn;
  logic                       fetch_valid;
  logic [31:0]                fetch_addr;
  logic                       run;
  logic                       halted;
  logic                       abort_act;
  logic                       irq;
  logic                       load_ok;
  logic [31:0]                rd_v;
  logic [1:0]                 rsp;
  flow_err_pkg::axil_req_t    req;
  flow_err_pkg::axil_rsp_t    rsp_b;
  flow_err_pkg::conv_events_t ev;
  int                         fail_count;
  int                         n_compared;
  int                         i;

  // Clock of 40 ns.
  always #20 aclk = ~aclk;

  ev_source src (.aclk(aclk), .ev(ev), .load_ok_indication(load_ok));

  adc_flow_error_flags DUT (
    .aclk(aclk), .aresetn(aresetn), .bus_req(req), .bus_rsp(rsp_b),
    .ev(ev), .load_ok_indication(load_ok), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .converter_run(run),
    .converter_halted(halted), .sequence_abort_active(abort_act),
    .irq(irq));

  // Compare one value and count it.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Bus write; address and data offered together, each released when taken.
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'h1;
    req.wvalid <= 1'h1;
    req.bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (rsp_b.awready) req.awvalid <= 1'h0;
      if (rsp_b.wready) req.wvalid <= 1'h0;
      if (rsp_b.bvalid) begin
        rsp = rsp_b.bresp;
        req.bready <= 1'h0;
        break;
      end
    end
  endtask : wr

  // Bus read.
  task rd(input logic [11:0] a);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (rsp_b.arready) req.arvalid <= 1'h0;
      if (rsp_b.rvalid) begin
        rd_v = rsp_b.rdata;
        rsp = rsp_b.rresp;
        req.rready <= 1'h0;
        break;
      end
    end
  endtask : rd

  // Register helpers.
  task flags(input logic [7:0] e);
    rd(flow_err_pkg::ERR_FLAGS_OFS);
    chk(rd_v, {24'h0, e});
  endtask : flags
  task clr;
    wr(flow_err_pkg::ERR_FLAGS_OFS, 32'h0000_000F);
  endtask : clr
  task ctl(input logic [3:0] c);
    wr(flow_err_pkg::CONTROL_OFS, {28'h0, c});
  endtask : ctl
  task fetch(input logic [31:0] a);
    @(posedge aclk);
    fetch_valid <= 1'h1;
    fetch_addr <= a;
    @(posedge aclk);
    fetch_valid <= 1'h0;
  endtask : fetch

  // Prints the counts and the verdict, then ends the run.
  task tally_and_finish;
    $display("compared %0d, wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    tally_and_finish;
  end

  // Main sequence.
  initial begin
    logic [31:0] adr [6];
    logic [3:0]  cv [5];
    logic [8:0]  cl [5];
    logic [7:0]  ex [5];
    adr = '{flow_err_pkg::NVM_LAST, flow_err_pkg::RAM_BASE,
            flow_err_pkg::RAM_LAST, flow_err_pkg::NVM_LAST + 1,
            flow_err_pkg::RAM_BASE - 1, flow_err_pkg::RAM_LAST + 1};
    cv = '{4'h1, 4'h1, 4'h9, 4'h1, 4'h1};
    cl = '{9'h000, EOL, EOA, EOA, ABR};
    ex = '{8'h04, 8'h00, 8'h00, 8'h04, 8'h00};
    aclk = 1'h0;
    aresetn = 1'h0;
    req = '0;
    fetch_valid = 1'h0;
    fetch_addr = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 4; i++) begin
      rd(12'(4 * i));
      chk(rd_v, 32'h0000_0000);
    end
    rd(12'h010);
    chk({30'h0, rsp}, {30'h0, flow_err_pkg::RESP_SLVERR});
    src.fire(TER);
    flags(8'h00);
    ctl(4'h1);
    src.fire(TER);
    flags(8'h08);
    chk({31'h0, halted}, 32'h0000_0001);
    clr;
    chk({31'h0, run}, 32'h0000_0001);
    for (i = 0; i < 6; i++) begin
      fetch(adr[i]);
      flags({7'h0, i > 2});
      chk({31'h0, halted}, {31'h0, i > 2});
      clr;
    end
    for (i = 0; i < 5; i++) begin
      ctl(cv[i]);
      src.fire(TRG);
      if (cl[i] != 9'h000) src.fire(cl[i]);
      src.fire(RST);
      flags(ex[i]);
      chk({31'h0, run}, 32'h0000_0001);
      clr;
      src.fire(RST);
      flags(8'h00);
      src.fire(RDN | ABD | EOL);
    end
    src.fire(TRG);
    src.fire(RST);
    flags(8'h04);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(flow_err_pkg::IRQ_MASK_OFS, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0001);
    clr;
    chk({31'h0, irq}, 32'h0000_0000);
    src.fire(RDN | EOL);
    ctl(4'h0);
    ctl(4'h3);
    src.fire(RST);
    flags(8'h00);
    src.fire(RST);
    flags(8'h02);
    chk({31'h0, run}, 32'h0000_0001);
    clr;
    src.set_ok(1'h1);
    src.fire(RST);
    flags(8'h00);
    src.set_ok(1'h0);
    src.fire(RST | ABR);
    flags(8'h00);
    src.fire(ABD);
    src.fire(ABR);
    src.fire(RST);
    flags(8'h00);
    chk({31'h0, abort_act}, 32'h0000_0001);
    src.fire(ABD);
    src.fire(STP);
    src.fire(RST);
    flags(8'h00);
    ctl(4'h7);
    src.fire(RST);
    src.fire(RST);
    flags(8'h00);
    ctl(4'h1);
    src.fire(RST);
    flags(8'h00);
    wr(12'h010, 32'h0000_000F);
    chk({30'h0, rsp}, {30'h0, flow_err_pkg::RESP_SLVERR});
    tally_and_finish;
  end
endmodule : adc_flow_error_flags_tb
